// ==== asrp_params.svh ====
// Register offsets, field positions and reset values of the audio serial receive port.
// Assumes an 8-bit register port with 8-bit data; included by bare name.
`ifndef ASRP_PARAMS_SVH
`define ASRP_PARAMS_SVH

// Register offsets
`define ASRP_OFS_IFACE 8'h00
`define ASRP_OFS_OFFSET 8'h04
`define ASRP_OFS_CLKCTL 8'h08
`define ASRP_OFS_BDIV 8'h0C
`define ASRP_OFS_PORT 8'h10
`define ASRP_OFS_STATUS 8'h14

// Interface control fields
`define ASRP_FMT_HI 7
`define ASRP_FMT_LO 6
`define ASRP_WL_HI 5
`define ASRP_WL_LO 4
`define ASRP_B_BDIR 3
`define ASRP_B_WDIR 2
`define ASRP_B_PULSE 1
`define ASRP_B_KEEP 0

// Clock control and port select fields
`define ASRP_B_INV 3
`define ASRP_SRC_HI 1
`define ASRP_SRC_LO 0
`define ASRP_B_SEC 0
`define ASRP_WSRC_HI 5
`define ASRP_WSRC_LO 4
`define ASRP_WSRC_SEC 2'h1
`define ASRP_SRC_MOD 2'h1

// Reset values
`define ASRP_RST_IFACE 8'h00
`define ASRP_RST_OFFSET 8'h00
`define ASRP_RST_CLKCTL 8'h00
`define ASRP_RST_BDIV 8'h01
`define ASRP_RST_PORT 8'h00

`endif

// ==== asrp_pkg.sv ====
// Types shared by the audio serial receive port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package asrp_pkg;

  // Framing formats, encoded as the format field
  typedef enum logic [1:0] {
    ASRP_I2S = 2'h0,
    ASRP_DSP = 2'h1,
    ASRP_RJ = 2'h2,
    ASRP_LJ = 2'h3
  } asrp_fmt_t;

  // Receive states, Gray coded along hunt, idle, left held
  typedef enum logic [1:0] {
    ASRP_HUNT = 2'h0,
    ASRP_IDLE = 2'h1,
    ASRP_HAVE_L = 2'h3
  } asrp_st_t;

  // Word length code to bit count
  function automatic logic [5:0] asrp_wl_bits(input logic [1:0] code);
    case (code)
      2'h0: asrp_wl_bits = 6'h10;
      2'h1: asrp_wl_bits = 6'h14;
      2'h2: asrp_wl_bits = 6'h18;
      default: asrp_wl_bits = 6'h20;
    endcase
  endfunction

endpackage

// ==== asrp_bclk_div.sv ====
// Bit clock generator: divides the selected source clock by 1 to 128.
// Assumes both source clocks arrive already synchronised to sys_clk.
`timescale 1ns/10ps
`include "asrp_params.svh"
module asrp_bclk_div (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic proc_s,
  input wire logic mod_s,
  input wire logic [1:0] src_sel,
  input wire logic [6:0] div,
  input wire logic run,
  output logic bclk,
  output logic bclk_fall
);
  import asrp_pkg::*;

  logic src_d;
  logic [6:0] cnt;
  logic src;
  logic trans;
  logic [6:0] nm1;

  // Source mux; every source transition is one half period, so divide 1 passes it through
  assign src = (src_sel == `ASRP_SRC_MOD) ? mod_s : proc_s; // RULE22
  assign trans = src ^ src_d;
  assign nm1 = div - 7'h01; // A zero field wraps to 127, so it divides by 128

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_d <= 1'b0;
    end else begin
      src_d <= src;
    end
  end

  // Half-period counter; stopped clock parks low so it restarts cleanly
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 7'h00;
      bclk <= 1'b0;
      bclk_fall <= 1'b0;
    end else if (!run) begin
      cnt <= 7'h00;
      bclk <= 1'b0;
      bclk_fall <= 1'b0;
    end else begin
      bclk_fall <= 1'b0;
      if (trans) begin
        if (cnt == nm1) begin // RULE21
          cnt <= 7'h00;
          bclk <= ~bclk;
          bclk_fall <= bclk;
        end else begin
          cnt <= cnt + 7'h01;
        end
      end
    end
  end

  AST_DIV_TOGGLE: assert property (@(posedge sys_clk) disable iff (rst) // RULE21
    ($changed(bclk) && $past(run)) |-> ($past(cnt) == $past(nm1) && $past(trans)))
    else $error("bit clock toggled before divider count completed");

  AST_DIV_SRC: assert property (@(posedge sys_clk) disable iff (rst) // RULE22
    (run && src_sel == `ASRP_SRC_MOD && mod_s == src_d && cnt != 7'h00) |=> $stable(cnt))
    else $error("divider counted without a modulator clock transition");

endmodule

// ==== asrp_port.sv ====
// Audio serial receive port: framing decoder, clock masters and register port.
// Assumes pins are asynchronous to sys_clk and the bit clock is well below sys_clk/4.
//
// Summary of operation
// (RULE1) Word length 16, 20, 24 or 32 bits from a two-bit field.
// (RULE2) Every format carries each sample most significant bit first.
// (RULE3) Word clock and bit clock directions are set separately.
// (RULE4) Word clock marks frame start at sample rate, pulse or square.
// (RULE5) Generated bit clock pulses per frame come from a programmable divider.
// (RULE6) Programmable bit-clock offset between frame start and first data bit.
// (RULE7) One bit inverts the data bit clock polarity in every format.
// (RULE8) Generated clocks run only while powered, unless keep-running is set.
// (RULE9) Right-justified: LSBs sit on the last edges before word clock changes.
// (RULE10) Right-justified frames carry at least twice the word length.
// (RULE11) Left-justified: MSB on first rising edge after each word clock change.
// (RULE12) Left-justified frames hold two words; offset leaves room for a word.
// (RULE13) I2S: MSB on second rising edge after each word clock change.
// (RULE14) I2S channels hold a word; offset leaves room for a word.
// (RULE15) DSP: falling word clock starts frame, left then right, falling edges.
// (RULE16) DSP frames hold two words; offset leaves room for a word.
// (RULE17) Primary or secondary pin set is served, one at a time.
// (RULE18) Word clock direction bit set drives the primary word clock pin.
// (RULE19) Primary word clock source is the sample-rate clock or secondary word clock.
// (RULE20) Bit clock direction bit set drives the bit clock pin.
// (RULE21) Generated bit clock is the source divided by 1 to 128.
// (RULE22) Divider source is the processing clock or the modulator clock.
// (RULE23) Bits outside the word are dropped; one stereo pair per frame.
`timescale 1ns/10ps
`include "asrp_params.svh"
module asrp_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic pri_wclk_i,
  output logic pri_wclk_o,
  output logic pri_wclk_oe_n,
  input wire logic pri_bclk_i,
  output logic pri_bclk_o,
  output logic pri_bclk_oe_n,
  input wire logic pri_din,
  input wire logic sec_wclk,
  input wire logic sec_bclk,
  input wire logic sec_din,
  input wire logic converter_sample_rate_clock,
  input wire logic processing_clock,
  input wire logic modulator_clock,
  input wire logic converter_powered,
  output logic [31:0] left_sample,
  output logic [31:0] right_sample,
  output logic sample_valid
);
  import asrp_pkg::*;

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic [7:0] r_iface;
  logic [7:0] r_ofs;
  logic [7:0] r_clk;
  logic [7:0] r_bdiv;
  logic [7:0] r_port;
  logic [9:0] s1;
  logic [9:0] s2;
  logic bck_d;
  logic wck_p;
  logic [9:0] pos;
  logic [31:0] sh;
  logic [31:0] left_h;
  logic [5:0] pair_cnt;
  logic pls;
  logic src_d;
  logic bclk_gen;
  logic bclk_fall;
  asrp_st_t st;
  asrp_fmt_t fmt;
  logic [1:0] wlc;
  logic restart;
  logic run;
  logic wck;
  logic bck;
  logic dat;
  logic s_fs;
  logic s_wck;
  logic wsrc;
  logic edge_ok;
  logic bnd;
  logic frame_start;
  logic [9:0] idx;
  logic [9:0] start;
  logic [9:0] wl;
  logic [9:0] ws;
  logic right_slot;
  logic in_win;
  logic last;
  logic cap;
  logic cap_right;
  logic [31:0] word;
  logic got_l;
  logic got_r;

  // Left-align a received word so narrow samples read as full-scale values
  function automatic logic [31:0] align_word(input logic [31:0] v, input logic [1:0] code);
    case (code)
      2'h0: align_word = {v[15:0], 16'h0000};
      2'h1: align_word = {v[19:0], 12'h000};
      2'h2: align_word = {v[23:0], 8'h00};
      default: align_word = v;
    endcase
  endfunction

  assign fmt = asrp_fmt_t'(r_iface[`ASRP_FMT_HI:`ASRP_FMT_LO]);
  assign wlc = r_iface[`ASRP_WL_HI:`ASRP_WL_LO]; // RULE1
  assign restart = wr && (addr == `ASRP_OFS_IFACE || addr == `ASRP_OFS_PORT);
  assign run = r_iface[`ASRP_B_KEEP] | s2[9]; // RULE8

  // Register writes; a write to format or port select restarts framing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r_iface <= `ASRP_RST_IFACE;
      r_ofs <= `ASRP_RST_OFFSET;
      r_clk <= `ASRP_RST_CLKCTL;
      r_bdiv <= `ASRP_RST_BDIV;
      r_port <= `ASRP_RST_PORT;
    end else if (wr) begin
      case (addr)
        `ASRP_OFS_IFACE: r_iface <= wdata;
        `ASRP_OFS_OFFSET: r_ofs <= wdata; // RULE6
        `ASRP_OFS_CLKCTL: r_clk <= wdata;
        `ASRP_OFS_BDIV: r_bdiv <= wdata; // RULE5
        `ASRP_OFS_PORT: r_port <= wdata;
        default: ;
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ASRP_OFS_IFACE: rdata <= r_iface;
        `ASRP_OFS_OFFSET: rdata <= r_ofs;
        `ASRP_OFS_CLKCTL: rdata <= r_clk;
        `ASRP_OFS_BDIV: rdata <= r_bdiv;
        `ASRP_OFS_PORT: rdata <= r_port;
        `ASRP_OFS_STATUS: rdata <= {pair_cnt, st};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Two-flop synchronisers for every pin; only stage two is read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1 <= 10'h000;
      s2 <= 10'h000;
    end else begin
      s1 <= {converter_powered, modulator_clock, processing_clock, converter_sample_rate_clock,
             sec_din, sec_bclk, sec_wclk, pri_din, pri_bclk_i, pri_wclk_i};
      s2 <= s1;
    end
  end

  // One pin set at a time; a driven primary clock reads back through its own pad
  assign wck = r_port[`ASRP_B_SEC] ? s2[3] : s2[0]; // RULE17
  assign bck = r_port[`ASRP_B_SEC] ? s2[4] : s2[1];
  assign dat = r_port[`ASRP_B_SEC] ? s2[5] : s2[2];
  assign s_fs = s2[6];
  assign s_wck = s2[3];

  // Sampling edge: rising by default, falling in DSP, swapped by the invert bit
  assign edge_ok = ((fmt == ASRP_DSP) ^ r_clk[`ASRP_B_INV]) ? (bck_d & ~bck) : (~bck_d & bck); // RULE7 RULE15

  // Slot decode from the bit position since the last frame or channel mark
  always_comb begin
    bnd = wck ^ wck_p;
    frame_start = bnd & ((fmt != ASRP_DSP) | ~wck); // RULE4
    idx = frame_start ? 10'h000 : pos;
    start = {2'h0, r_ofs} + ((fmt == ASRP_I2S) ? 10'h001 : 10'h000); // RULE6 RULE13
    wl = {4'h0, asrp_wl_bits(wlc)};
    case (fmt)
      ASRP_DSP: right_slot = idx >= start + wl; // RULE15
      ASRP_I2S: right_slot = wck; // RULE13
      default: right_slot = ~wck; // RULE11
    endcase
    ws = (fmt == ASRP_DSP && right_slot) ? start + wl : start;
    in_win = (idx >= ws) && (idx < ws + wl); // RULE23
    last = idx == ws + wl - 10'h001;
  end

  // Right-justified words end at the channel mark; others at the window end
  assign cap = edge_ok & ((fmt == ASRP_RJ) ? bnd : (in_win & last)); // RULE9
  assign cap_right = (fmt == ASRP_RJ) ? ~wck_p : right_slot;
  assign word = align_word((fmt == ASRP_RJ) ? sh : {sh[30:0], dat}, wlc); // RULE2
  assign got_l = cap & ~cap_right & (st != ASRP_HUNT);
  assign got_r = cap & cap_right & (st == ASRP_HAVE_L);

  // Edge history of the selected clocks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bck_d <= 1'b0;
      wck_p <= 1'b0;
    end else begin
      bck_d <= bck;
      // A restart takes the present level as reference, so the next change, in DSP the next fall, counts as a frame mark
      if (edge_ok || restart) begin
        wck_p <= wck;
      end
    end
  end

  // Bit position counter saturates so a missing word clock cannot wrap it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos <= 10'h000;
    end else if (restart) begin
      pos <= 10'h000;
    end else if (edge_ok) begin
      pos <= (idx == 10'h3FF) ? idx : idx + 10'h001;
    end
  end

  // Shift register, MSB first; right-justified keeps shifting to hold the tail
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh <= 32'h00000000;
    end else if (edge_ok && (in_win || fmt == ASRP_RJ)) begin
      sh <= {sh[30:0], dat}; // RULE2 RULE23
    end
  end

  // Pair tracker; hunts for a frame mark after reset or reconfiguration
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= ASRP_HUNT;
    end else if (restart) begin
      st <= ASRP_HUNT; // RULE17
    end else begin
      case (st)
        ASRP_HUNT: if (edge_ok && frame_start) begin
          st <= ASRP_IDLE;
        end
        ASRP_IDLE: if (got_l) begin
          st <= ASRP_HAVE_L;
        end
        ASRP_HAVE_L: if (got_r) begin
          st <= ASRP_IDLE;
        end
        default: st <= ASRP_HUNT;
      endcase
    end
  end

  // Left word is held until its right partner arrives, then both leave together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left_h <= 32'h00000000;
      left_sample <= 32'h00000000;
      right_sample <= 32'h00000000;
      sample_valid <= 1'b0;
      pair_cnt <= 6'h00;
    end else begin
      sample_valid <= 1'b0;
      if (got_l) begin
        left_h <= word;
      end
      if (got_r) begin
        left_sample <= left_h; // RULE23
        right_sample <= word;
        sample_valid <= 1'b1;
        pair_cnt <= pair_cnt + 6'h01;
      end
    end
  end

  sequence s_pair_done;
    got_r ##1 sample_valid;
  endsequence

  AST_PAIR_ONCE: assert property (got_r |-> s_pair_done ##1 !sample_valid) // RULE23
    else $error("stereo pair not delivered as a single pulse");

  AST_WL_ZERO: assert property ((got_r && wlc == 2'h0) |=> // RULE1
    (left_sample[15:0] == 16'h0000 && right_sample[15:0] == 16'h0000))
    else $error("bits beyond a 16-bit word reached the converter");

  AST_LSB_LAST: assert property ((got_l && wlc == 2'h3 && fmt != ASRP_RJ) |=> // RULE2
    left_h[0] == $past(dat))
    else $error("last received bit did not land in the least significant bit");

  AST_RESTART: assert property (restart |=> (st == ASRP_HUNT && pos == 10'h000)) // RULE17
    else $error("port reconfiguration did not restart framing");

  // Master word clock source and optional one-bit-clock pulse form
  assign wsrc = (r_port[`ASRP_WSRC_HI:`ASRP_WSRC_LO] == `ASRP_WSRC_SEC) ? s_wck : s_fs; // RULE19

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_d <= 1'b0;
      pls <= 1'b0;
    end else begin
      src_d <= wsrc;
      if (wsrc && !src_d) begin
        pls <= 1'b1; // RULE4
      end else if (bclk_fall) begin
        pls <= 1'b0;
      end
    end
  end

  asrp_bclk_div u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .proc_s(s2[7]),
    .mod_s(s2[8]),
    .src_sel(r_clk[`ASRP_SRC_HI:`ASRP_SRC_LO]),
    .div(r_bdiv[6:0]),
    .run(run),
    .bclk(bclk_gen),
    .bclk_fall(bclk_fall)
  );

  // Pin drivers; clocks park low while the converter sleeps with keep-running clear, which saves power
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pri_wclk_o <= 1'b0;
      pri_bclk_o <= 1'b0;
      pri_wclk_oe_n <= 1'b1;
      pri_bclk_oe_n <= 1'b1;
    end else begin
      pri_wclk_o <= run & (r_iface[`ASRP_B_PULSE] ? pls : wsrc); // RULE8
      pri_bclk_o <= bclk_gen; // RULE5
      pri_wclk_oe_n <= ~r_iface[`ASRP_B_WDIR]; // RULE3 RULE18
      pri_bclk_oe_n <= ~r_iface[`ASRP_B_BDIR]; // RULE3 RULE20
    end
  end

  sequence s_wdir_set;
    wr && addr == `ASRP_OFS_IFACE && wdata[`ASRP_B_WDIR];
  endsequence

  sequence s_bdir_set;
    wr && addr == `ASRP_OFS_IFACE && wdata[`ASRP_B_BDIR];
  endsequence

  sequence s_asleep;
    !run ##1 !run;
  endsequence

  AST_WCLK_DRIVE: assert property (s_wdir_set |=> ##1 !pri_wclk_oe_n) // RULE18
    else $error("word clock pin not driven after direction set");

  AST_BCLK_DRIVE: assert property (s_bdir_set |=> ##1 !pri_bclk_oe_n) // RULE20
    else $error("bit clock pin not driven after direction set");

  AST_CLK_GATE: assert property (s_asleep |=> (!pri_bclk_o && !pri_wclk_o)) // RULE8
    else $error("generated clocks kept running while powered down");

  AST_WCLK_SRC: assert property ((run && !r_iface[`ASRP_B_PULSE] && // RULE19
    r_port[`ASRP_WSRC_HI:`ASRP_WSRC_LO] == `ASRP_WSRC_SEC) |=> pri_wclk_o == $past(s_wck))
    else $error("primary word clock not following the secondary word clock");

endmodule

// ==== asrp_host_model.sv ====
// Host processor model: sends stereo frames on a word clock, a bit clock and a data line.
// Assumes sys_clk from the bench; the format inputs mirror what the port was told.
`timescale 1ns/10ps
module asrp_host_model (
  input wire logic sys_clk,
  input wire asrp_pkg::asrp_fmt_t fmt,
  input wire logic [5:0] wlb,
  input wire logic [7:0] off,
  input wire logic inv,
  output logic wclk,
  output logic bclk,
  output logic din
);
  import asrp_pkg::*;
  localparam int SLOT = 40; // Bit clocks per channel, room for I2S with 32 bits
  integer seed = 32'hBFC0FCBE;
  logic busy = 1'b0;
  logic act;
  logic lvl_l;
  // Level after the sampling edge, and word clock level of the first slot
  assign act = (fmt != ASRP_DSP) ^ inv;
  assign lvl_l = (fmt == ASRP_DSP) ? 1'b0 : (fmt != ASRP_I2S);
  initial begin
    wclk = 1'b0;
    bclk = 1'b0;
    din = 1'b0;
  end
  // Released data line toggles at random, so a late sample cannot match by luck
  always @(posedge sys_clk) begin
    if (!busy) begin
      din <= 1'($random(seed));
    end
  end
  // Data bit at frame position q, or filler outside the word
  function automatic logic bit_at(input int q, input logic [31:0] l, input logic [31:0] r);
    int p;
    int s;
    int n;
    logic [31:0] w;
    n = int'(wlb);
    p = q % SLOT;
    w = (q < SLOT) ? l : r;
    s = int'(off);
    if (fmt == ASRP_I2S) s = s + 1;
    if (fmt == ASRP_RJ) s = SLOT - n;
    if (fmt == ASRP_DSP) begin
      p = q - s;
      s = 0;
      w = (p < n) ? l : r;
      if (p >= n) p = p - n;
    end
    if (p >= s && p - s < n) return w[31 - (p - s)];
    return 1'($random(seed));
  endfunction
  // One bit clock: data and word clock change, then the sampling edge mid-period
  task automatic bit_period(input logic w, input logic d);
    @(posedge sys_clk);
    wclk <= w;
    din <= d;
    bclk <= ~act;
    repeat (4) @(posedge sys_clk);
    bclk <= act;
    repeat (3) @(posedge sys_clk);
  endtask
  // Park both lines at the idle levels before the port is configured
  task automatic prime();
    @(posedge sys_clk);
    bclk <= act;
    wclk <= ~lvl_l;
  endtask
  // A whole frame, left slot then right slot; the bit clock stands still after it
  task automatic send_frame(input logic [31:0] l, input logic [31:0] r);
    busy = 1'b1;
    for (int q = 0; q < 2 * SLOT; q++) begin
      bit_period((fmt == ASRP_DSP) ? (q == 2 * SLOT - 1) : ((q < SLOT) ? lvl_l : ~lvl_l), bit_at(q, l, r));
    end
  endtask
  // Marks the end of the last frame with a stub that the port must drop
  task automatic close();
    bit_period(lvl_l, 1'b0);
    bit_period(~lvl_l, 1'b1);
    busy = 1'b0;
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the audio serial receive port, with a host model on its pins.
// Assumes the port's register map and asrp_host_model.
`timescale 1ns/10ps
module testbench;
  import asrp_pkg::*;
  localparam int LIMIT = 40000; // Cycles; the whole run needs about 20000
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata;
  logic wclk_o, wclk_oe_n, bclk_o, bclk_oe_n;
  logic h_wclk, h_bclk, h_din;
  logic sec_sel = 1'b0;
  logic fs_clk = 1'b0;
  logic proc_clk = 1'b0;
  logic mod_clk = 1'b0;
  logic powered = 1'b1;
  logic [7:0] junk = 8'h00;
  logic [31:0] left_sample, right_sample;
  logic sample_valid;
  asrp_fmt_t fmt = ASRP_LJ;
  logic [5:0] wlb = 6'h10;
  logic [7:0] off = 8'h00;
  logic inv = 1'b0;
  integer seed = 32'hBFC0FCBE;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [63:0] exp_q[$];
  // Receive cases: format, word length code, offset, invert, secondary set
  logic [13:0] cases [8] = '{{2'h3, 2'h0, 8'h00, 1'b0, 1'b0}, {2'h3, 2'h2, 8'h03, 1'b1, 1'b0},
    {2'h0, 2'h3, 8'h00, 1'b0, 1'b1}, {2'h0, 2'h1, 8'h02, 1'b1, 1'b0}, {2'h1, 2'h0, 8'h01, 1'b0, 1'b0},
    {2'h1, 2'h3, 8'h00, 1'b1, 1'b1}, {2'h2, 2'h2, 8'h05, 1'b0, 1'b0}, {2'h2, 2'h3, 8'h00, 1'b1, 1'b1}};
  // Pads: a driven clock loops back; the unselected set carries a slow counter pattern
  wire pri_wclk = wclk_oe_n ? (sec_sel ? junk[5] : h_wclk) : wclk_o;
  wire pri_bclk = bclk_oe_n ? (sec_sel ? junk[2] : h_bclk) : bclk_o;
  // Clocks: sources at an eighth and a sixth of sys_clk, fs much slower
  always #10 sys_clk = ~sys_clk;
  always #80 proc_clk = ~proc_clk;
  always #60 mod_clk = ~mod_clk;
  always #1000 fs_clk = ~fs_clk;
  asrp_port dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pri_wclk_i(pri_wclk), .pri_wclk_o(wclk_o), .pri_wclk_oe_n(wclk_oe_n), .pri_bclk_i(pri_bclk),
    .pri_bclk_o(bclk_o), .pri_bclk_oe_n(bclk_oe_n), .pri_din(sec_sel ? junk[1] : h_din),
    .sec_wclk(sec_sel ? h_wclk : junk[5]), .sec_bclk(sec_sel ? h_bclk : junk[2]),
    .sec_din(sec_sel ? h_din : junk[1]), .converter_sample_rate_clock(fs_clk), .processing_clock(proc_clk),
    .modulator_clock(mod_clk), .converter_powered(powered), .left_sample(left_sample),
    .right_sample(right_sample), .sample_valid(sample_valid));
  asrp_host_model host (.sys_clk(sys_clk), .fmt(fmt), .wlb(wlb), .off(off), .inv(inv), .wclk(h_wclk),
    .bclk(h_bclk), .din(h_din));
  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Oldest note against what just appeared; a result with no note is a fault too
  task automatic take(input logic [63:0] seen);
    if (exp_q.size() == 0) begin
      errors++;
      $display("unexpected at %0t: result %h with nothing pending", $time, seen);
    end else begin
      check(seen, exp_q.pop_front());
    end
  endtask
  // Watches read data, received pairs and the time limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    junk <= junk + 8'h01;
    rd_d <= rd;
    if (rd_d) begin
      take({56'h0, rdata});
    end
    if (sample_valid === 1'b1) begin
      take({left_sample, right_sample});
    end
    if (cycles == LIMIT) begin
      errors++;
      $display("unexpected at %0t: time limit reached", $time);
      complete_run();
    end
  end
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({56'h0, e});
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask
  // Cycles between two toggles of the generated bit clock
  task automatic toggle_gap(output int n);
    logic v;
    n = 0;
    v = bclk_o;
    while (bclk_o === v && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    v = bclk_o;
    n = 0;
    while (bclk_o === v && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // Three random frames in one setting; extra bits around each word are noise
  task automatic rx_case(input logic [13:0] t);
    logic [31:0] l;
    logic [31:0] r;
    logic [31:0] m;
    @(posedge sys_clk);
    fmt <= asrp_fmt_t'(t[13:12]);
    wlb <= (t[11:10] == 2'h3) ? 6'h20 : 6'h10 + {t[11:10], 2'h0};
    off <= t[9:2];
    inv <= t[1];
    sec_sel <= t[0];
    host.prime();
    reg_wr(8'h08, {4'h0, t[1], 3'h0});
    reg_wr(8'h04, t[9:2]);
    reg_wr(8'h10, {7'h00, t[0]});
    reg_wr(8'h00, {t[13:10], 4'h0});
    repeat (8) @(posedge sys_clk);
    m = ~(32'hFFFFFFFF >> wlb);
    repeat (3) begin
      l = $random(seed);
      r = $random(seed);
      exp_q.push_back({l & m, r & m});
      host.send_frame(l, r);
    end
    host.close();
    repeat (8) @(posedge sys_clk);
    check(64'(exp_q.size()), 64'h0);
  endtask
  initial begin
    int n;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, an unmapped place and a read-back
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h0C, 8'h01);
    reg_rd(8'h08, 8'h00);
    reg_rd(8'h10, 8'h00);
    reg_wr(8'h20, 8'h5A);
    reg_rd(8'h20, 8'h00);
    reg_wr(8'h04, 8'hC3);
    reg_rd(8'h04, 8'hC3);
    for (int i = 0; i < 8; i++) begin
      rx_case(cases[i]);
    end
    // Master clocks: divide by 2 from the processing clock, then by 128 from the modulator
    reg_wr(8'h0C, 8'h02);
    reg_wr(8'h08, 8'h00);
    reg_wr(8'h00, 8'h0C);
    repeat (4) @(posedge sys_clk);
    check({bclk_oe_n, wclk_oe_n}, 64'h0);
    toggle_gap(n);
    toggle_gap(n);
    check(64'(n), 64'h8);
    reg_wr(8'h08, 8'h01);
    reg_wr(8'h0C, 8'h00);
    toggle_gap(n);
    toggle_gap(n);
    check(64'(n), 64'h180);
    @(posedge fs_clk);
    repeat (25) @(posedge sys_clk);
    check(wclk_o, fs_clk);
    // Secondary word clock now carries the counter pattern
    sec_sel <= 1'b0;
    reg_wr(8'h10, 8'h10);
    repeat (4) @(posedge sys_clk);
    @(posedge sys_clk iff junk[4:0] == 5'h10);
    check(wclk_o, junk[5]);
    // Powered down: clocks stop unless the keep-running bit is set
    powered <= 1'b0;
    reg_wr(8'h0C, 8'h02);
    reg_wr(8'h08, 8'h00);
    repeat (20) @(posedge sys_clk);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (bclk_o !== 1'b0) n++;
    end
    check(64'(n), 64'h0);
    reg_wr(8'h00, 8'h0D);
    toggle_gap(n);
    toggle_gap(n);
    check(64'(n), 64'h8);
    // Pulse form from the sample-rate clock: high after its rise, gone by the next bit clock fall
    reg_wr(8'h10, 8'h00);
    reg_wr(8'h00, 8'h0F);
    @(posedge fs_clk);
    repeat (5) @(posedge sys_clk);
    check(wclk_o, 1'b1);
    repeat (25) @(posedge sys_clk);
    check(wclk_o, 1'b0);
    powered <= 1'b1;
    reg_wr(8'h00, 8'h00);
    repeat (4) @(posedge sys_clk);
    check({bclk_oe_n, wclk_oe_n}, 64'h3);
    complete_run();
  end
endmodule
